// >>> core/core_pkg.sv
// Operation
// - The clock is divided by four into four non-overlapping phases that make one instruction cycle.
// - The program counter steps once per instruction cycle, in phase_one, which opens each fetch.
// - A fetched word enters the instruction latch at the next phase_one and runs in phases two to four.
// - Fetch of the next word overlaps execution of the current one, one instruction per cycle.
// - The data operand is read in phase_two and the destination is written in phase_four.
// - A change of program counter discards the fetched word, so a branch takes two cycles.
// - An 8-bit ALU and an 8-bit working register operate with any register file location.
// - The ALU adds, subtracts, shifts and does logic, in two's complement arithmetic.
// - Two-operand ops use the working register with a file register or literal; one-operand ops use either.
// - Each instruction updates carry, half carry and zero flags as its kind demands.
// - Subtraction leaves carry as an inverted borrow and half carry as an inverted nibble borrow.
// - Instructions come only from internal program memory of 4096 words of 14 bits.
// - Special registers, the program counter low byte among them, sit in data memory space.
// - Reset starts fetching at address zero and interrupts vector to address four.
`default_nettype none

package core_pkg;
  localparam int PHASES = 4;
  localparam int PROG_WORDS = 4096;
  localparam int PC_W = 12;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;

  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} phase_e;

  localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
  localparam logic [PC_W-1:0] INT_VECTOR = 12'h004;

  // Instruction classes in bits 13:12
  localparam logic [1:0] CLS_FILE = 2'h0;
  localparam logic [1:0] CLS_GOTO = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;

  // Operation codes in bits 11:8
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_MOVWF = 4'h1;
  localparam logic [3:0] OP_MOVF = 4'h2;
  localparam logic [3:0] OP_ADD = 4'h3;
  localparam logic [3:0] OP_SUB = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_IOR = 4'h6;
  localparam logic [3:0] OP_XOR = 4'h7;
  localparam logic [3:0] OP_RLF = 4'h8;
  localparam logic [3:0] OP_RRF = 4'h9;
  localparam logic [3:0] OP_COMF = 4'ha;
  localparam logic [3:0] OP_INCF = 4'hb;
  localparam logic [3:0] OP_DECF = 4'hc;
  localparam logic [3:0] OP_CLR = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;

  // Special register addresses in data space
  localparam logic [7:0] ADDR_INDIRECT = 8'h00;
  localparam logic [7:0] ADDR_PCL = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_FSR = 8'h04;

  // Status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
endpackage

`default_nettype wire

// >>> core/phase_gen.sv
`default_nettype none

module phase_gen
  import core_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  output logic [PHASES-1:0] phase
);
  phase_e state_r;
  phase_e state_nxt;
  logic [PHASES-1:0] phase_nxt;

  always_comb
  begin
    unique case (state_r)
      PH_ONE: state_nxt = PH_TWO;
      PH_TWO: state_nxt = PH_THREE;
      PH_THREE: state_nxt = PH_FOUR;
      PH_FOUR: state_nxt = PH_ONE;
    endcase
  end

  assign phase_nxt = 4'h1 << state_nxt;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= PH_ONE;
      phase <= 4'h1;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      phase <= phase_nxt;
    end
  end
endmodule

`default_nettype wire

// >>> core/alu8.sv
`default_nettype none

module alu8
  import core_pkg::*;
(
  input wire logic [3:0] op,
  input wire logic [DATA_W-1:0] opnd,
  input wire logic [DATA_W-1:0] w,
  input wire logic c_in,
  output logic [DATA_W-1:0] res,
  output logic c_out,
  output logic dc_out,
  output logic z_out,
  output logic upd_c,
  output logic upd_dc,
  output logic upd_z
);
  logic [DATA_W:0] add_full;
  logic [DATA_W:0] sub_full;
  logic [4:0] add_nib;
  logic [4:0] sub_nib;

  assign add_full = {1'b0, opnd} + {1'b0, w};
  // Subtract as opnd + ~w + 1 so the carry out is the inverted borrow
  assign sub_full = {1'b0, opnd} + {1'b0, ~w} + 9'h001;
  assign add_nib = {1'b0, opnd[3:0]} + {1'b0, w[3:0]};
  assign sub_nib = {1'b0, opnd[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
  assign z_out = (res == 8'h00);

  always_comb
  begin
    res = opnd;
    c_out = c_in;
    dc_out = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b1;
    unique case (op)
      OP_ADD:
      begin
        {c_out, res} = add_full;
        dc_out = add_nib[4];
        upd_c = 1'b1;
        upd_dc = 1'b1;
      end
      OP_SUB:
      begin
        {c_out, res} = sub_full;
        dc_out = sub_nib[4];
        upd_c = 1'b1;
        upd_dc = 1'b1;
      end
      OP_AND: res = opnd & w;
      OP_IOR: res = opnd | w;
      OP_XOR: res = opnd ^ w;
      OP_RLF:
      begin
        {c_out, res} = {opnd, c_in};
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      OP_RRF:
      begin
        {res, c_out} = {c_in, opnd};
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      OP_COMF: res = ~opnd;
      OP_INCF: res = opnd + 8'h01;
      OP_DECF: res = opnd - 8'h01;
      OP_CLR: res = 8'h00;
      OP_SWAP:
      begin
        res = {opnd[3:0], opnd[7:4]};
        upd_z = 1'b0;
      end
      OP_MOVWF:
      begin
        res = w;
        upd_z = 1'b0;
      end
      OP_MOVF: res = opnd;
      default: upd_z = 1'b0;
    endcase
  end
endmodule

`default_nettype wire

// >>> core/quad_phase_fetch_execute_core.sv
`default_nettype none

module quad_phase_fetch_execute_core
  import core_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic MASTER_CLEAR_PIN_N,
  input wire logic INT_REQ,
  input wire logic [INSTR_W-1:0] PROG_DATA,
  input wire logic [DATA_W-1:0] DATA_RDATA,
  output logic [PHASES-1:0] PHASE,
  output logic [PC_W-1:0] PROG_ADDR,
  output logic [7:0] DATA_ADDR,
  output logic DATA_RD_EN,
  output logic DATA_WR_EN,
  output logic [DATA_W-1:0] DATA_WDATA,
  output logic [DATA_W-1:0] WORK_REG,
  output logic [2:0] STATUS_FLAGS
);
  // Master clear pin synchroniser
  logic master_clear_pin_meta_r;
  logic master_clear_pin_sync_r;
  logic rst_core;

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      master_clear_pin_meta_r <= 1'b1;
      master_clear_pin_sync_r <= 1'b1;
    end
    else if (CE)
    begin
      master_clear_pin_meta_r <= MASTER_CLEAR_PIN_N;
      master_clear_pin_sync_r <= master_clear_pin_meta_r;
    end
  end

  assign rst_core = RST | ~master_clear_pin_sync_r;

  logic ph_one;
  logic ph_two;
  logic ph_three;
  logic ph_four;

  phase_gen u_phase (
    .clk(CORE_CLK),
    .rst(rst_core),
    .ce(CE),
    .phase(PHASE)
  );

  assign ph_one = PHASE[0];
  assign ph_two = PHASE[1];
  assign ph_three = PHASE[2];
  assign ph_four = PHASE[3];

  // Pipeline state
  logic [PC_W-1:0] program_counter_r;
  logic [INSTR_W-1:0] fetch_r;
  logic fetch_valid_r;
  logic [INSTR_W-1:0] instruction_latch_r;
  logic instr_valid_r;
  logic [DATA_W-1:0] fsr_r;
  logic carry_flag_r;
  logic half_carry_flag_r;
  logic zero_flag_r;
  logic [DATA_W-1:0] result_r;
  logic res_c_r;
  logic res_dc_r;
  logic res_z_r;
  logic upd_c_r;
  logic upd_dc_r;
  logic upd_z_r;

  // In phase_one decode looks at the word about to enter the latch
  logic [INSTR_W-1:0] cur_word;
  logic cur_valid;
  logic [1:0] cls;
  logic [3:0] op;
  logic dst_file;
  logic [7:0] lit;
  logic [PC_W-1:0] target;
  logic is_file;
  logic is_lit;
  logic is_goto;
  logic [7:0] eff_addr;
  logic hit_zero;
  logic hit_pcl;
  logic hit_status;
  logic hit_fsr;
  logic sfr_int;
  logic needs_read;
  logic writes_file;
  logic writes_w;
  logic single_op;

  assign cur_word = ph_one ? fetch_r : instruction_latch_r;
  assign cur_valid = ph_one ? fetch_valid_r : instr_valid_r;
  assign cls = cur_word[13:12];
  assign op = cur_word[11:8];
  assign dst_file = cur_word[7];
  assign lit = cur_word[7:0];
  assign target = cur_word[PC_W-1:0];
  assign is_file = cur_valid & (cls == CLS_FILE);
  assign is_lit = cur_valid & (cls == CLS_LIT);
  assign is_goto = cur_valid & (cls == CLS_GOTO);
  // Address zero reaches data memory through the pointer register
  assign eff_addr = ({1'b0, cur_word[6:0]} == ADDR_INDIRECT) ? fsr_r : {1'b0, cur_word[6:0]};
  assign hit_zero = (eff_addr == ADDR_INDIRECT);
  assign hit_pcl = (eff_addr == ADDR_PCL);
  assign hit_status = (eff_addr == ADDR_STATUS);
  assign hit_fsr = (eff_addr == ADDR_FSR);
  assign sfr_int = hit_zero | hit_pcl | hit_status | hit_fsr;
  assign needs_read = is_file & (op != OP_NOP) & (op != OP_MOVWF) & (op != OP_CLR);
  assign writes_file = is_file & (op != OP_NOP) & ((op == OP_MOVWF) | dst_file);
  assign writes_w = (is_file & (op != OP_NOP) & (op != OP_MOVWF) & ~dst_file)
                  | (is_lit & (op != OP_NOP) & (op != OP_MOVWF));
  assign single_op = (op == OP_RLF) | (op == OP_RRF) | (op == OP_COMF) | (op == OP_INCF)
                   | (op == OP_DECF) | (op == OP_CLR) | (op == OP_SWAP);

  // Operand selection for the ALU
  logic [DATA_W-1:0] sfr_rdata;
  logic [DATA_W-1:0] file_val;
  logic [DATA_W-1:0] alu_opnd;
  logic [DATA_W-1:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic alu_upd_c;
  logic alu_upd_dc;
  logic alu_upd_z;

  assign sfr_rdata = hit_pcl ? program_counter_r[7:0]
                   : hit_status ? {5'h00, zero_flag_r, half_carry_flag_r, carry_flag_r}
                   : hit_fsr ? fsr_r
                   : 8'h00;
  assign file_val = sfr_int ? sfr_rdata : DATA_RDATA;
  // Literal forms take the literal as second operand, or W for one-operand ops
  assign alu_opnd = is_file ? file_val : (single_op ? WORK_REG : lit);

  alu8 u_alu (
    .op(op),
    .opnd(alu_opnd),
    .w(WORK_REG),
    .c_in(carry_flag_r),
    .res(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z),
    .upd_c(alu_upd_c),
    .upd_dc(alu_upd_dc),
    .upd_z(alu_upd_z)
  );

  // Change of flow decided at the end of phase_four
  logic pcl_write;
  logic flush;
  logic [PC_W-1:0] pc_jump;

  assign pcl_write = writes_file & hit_pcl;
  assign flush = is_goto | pcl_write | INT_REQ;
  assign pc_jump = is_goto ? target
                 : pcl_write ? {program_counter_r[PC_W-1:8], result_r}
                 : INT_VECTOR;

  // Fetch side
  always_ff @(posedge CORE_CLK)
  begin
    if (rst_core)
    begin
      program_counter_r <= RESET_VECTOR;
      PROG_ADDR <= RESET_VECTOR;
      fetch_r <= 14'h0000;
      fetch_valid_r <= 1'b0;
    end
    else if (CE)
    begin
      if (ph_one)
      begin
        PROG_ADDR <= program_counter_r;
        program_counter_r <= program_counter_r + 12'h001;
      end
      if (ph_four)
      begin
        fetch_r <= PROG_DATA;
        fetch_valid_r <= ~flush;
        if (flush)
        begin
          program_counter_r <= pc_jump;
        end
      end
    end
  end

  // Instruction latch
  always_ff @(posedge CORE_CLK)
  begin
    if (rst_core)
    begin
      instruction_latch_r <= 14'h0000;
      instr_valid_r <= 1'b0;
    end
    else if (CE && ph_one)
    begin
      instruction_latch_r <= fetch_r;
      instr_valid_r <= fetch_valid_r;
    end
  end

  // Data memory port
  always_ff @(posedge CORE_CLK)
  begin
    if (rst_core)
    begin
      DATA_ADDR <= 8'h00;
      DATA_RD_EN <= 1'b0;
      DATA_WR_EN <= 1'b0;
      DATA_WDATA <= 8'h00;
    end
    else if (CE)
    begin
      if (ph_one)
      begin
        DATA_ADDR <= eff_addr;
        DATA_RD_EN <= needs_read & ~sfr_int;
      end
      if (ph_two)
      begin
        DATA_RD_EN <= 1'b0;
      end
      if (ph_three)
      begin
        DATA_WR_EN <= writes_file & ~sfr_int;
        DATA_WDATA <= alu_res;
      end
      if (ph_four)
      begin
        DATA_WR_EN <= 1'b0;
      end
    end
  end

  // Result capture in phase_three
  always_ff @(posedge CORE_CLK)
  begin
    if (rst_core)
    begin
      result_r <= 8'h00;
      res_c_r <= 1'b0;
      res_dc_r <= 1'b0;
      res_z_r <= 1'b0;
      upd_c_r <= 1'b0;
      upd_dc_r <= 1'b0;
      upd_z_r <= 1'b0;
    end
    else if (CE && ph_three)
    begin
      result_r <= alu_res;
      res_c_r <= alu_c;
      res_dc_r <= alu_dc;
      res_z_r <= alu_z;
      upd_c_r <= alu_upd_c & (is_file | is_lit);
      upd_dc_r <= alu_upd_dc & (is_file | is_lit);
      upd_z_r <= alu_upd_z & (is_file | is_lit);
    end
  end

  // Destination write in phase_four
  always_ff @(posedge CORE_CLK)
  begin
    if (rst_core)
    begin
      WORK_REG <= 8'h00;
      fsr_r <= 8'h00;
      carry_flag_r <= 1'b0;
      half_carry_flag_r <= 1'b0;
      zero_flag_r <= 1'b0;
    end
    else if (CE && ph_four)
    begin
      if (writes_w)
      begin
        WORK_REG <= result_r;
      end
      if (writes_file && hit_fsr)
      begin
        fsr_r <= result_r;
      end
      // A direct write to the status register wins over flag updates
      if (writes_file && hit_status)
      begin
        carry_flag_r <= result_r[ST_C];
        half_carry_flag_r <= result_r[ST_DC];
        zero_flag_r <= result_r[ST_Z];
      end
      else
      begin
        if (upd_c_r)
        begin
          carry_flag_r <= res_c_r;
        end
        if (upd_dc_r)
        begin
          half_carry_flag_r <= res_dc_r;
        end
        if (upd_z_r)
        begin
          zero_flag_r <= res_z_r;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (rst_core)
    begin
      STATUS_FLAGS <= 3'h0;
    end
    else if (CE)
    begin
      STATUS_FLAGS <= {zero_flag_r, half_carry_flag_r, carry_flag_r};
    end
  end
endmodule

`default_nettype wire

// >>> bench/mem_model.sv
`default_nettype none

module mem_model
  import core_pkg::*;
(
  input wire logic clk,
  input wire logic [PC_W-1:0] prog_addr,
  output logic [INSTR_W-1:0] prog_data,
  input wire logic [7:0] data_addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [INSTR_W-1:0] rom [PROG_WORDS];
  logic [DATA_W-1:0] ram [256];

  assign prog_data = rom[prog_addr];

  // Read data is taken in phase_two; outside a read it toggles so stale data never looks valid
  always @(posedge clk)
  begin
    rdata <= rd_en ? ram[data_addr] : ~rdata;
    if (wr_en)
      ram[data_addr] <= wdata;
  end
endmodule

`default_nettype wire

// >>> bench/core_props.sv
`default_nettype none

module core_props
  import core_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic MASTER_CLEAR_PIN_N,
  input wire logic [PHASES-1:0] PHASE,
  input wire logic [PC_W-1:0] PROG_ADDR,
  input wire logic [7:0] DATA_ADDR,
  input wire logic DATA_RD_EN,
  input wire logic DATA_WR_EN,
  input wire logic [DATA_W-1:0] WORK_REG,
  input wire logic [2:0] STATUS_FLAGS
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] pin_r;
  logic busy;
  logic [PHASES-1:0] rot;

  assign rot = {PHASE[2:0], PHASE[3]};
  // Covers the pin's synchroniser delay after master clear is released
  assign busy = RST || !MASTER_CLEAR_PIN_N || !(&pin_r);

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      pin_r <= 4'hf;
    else if (CE)
      pin_r <= {pin_r[2:0], MASTER_CLEAR_PIN_N};
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (busy);

  sequence no_access_s;
    !DATA_RD_EN && !DATA_WR_EN;
  endsequence

  sequence fetch_only_s;
    no_access_s [*5];
  endsequence

  AST_PHASE_ROTATE: assert property (CE |=> PHASE == $past(rot))
    else $error("phase did not advance one step");
  AST_PHASE_HOLD: assert property (!CE |=> $stable(PHASE))
    else $error("phase moved while disabled");
  AST_PC_SLOT: assert property (!PHASE[0] |=> $stable(PROG_ADDR))
    else $error("program address moved outside phase one");
  AST_RD_SLOT: assert property (DATA_RD_EN |-> PHASE[1])
    else $error("data read outside phase two");
  AST_WR_SLOT: assert property (DATA_WR_EN |-> PHASE[3])
    else $error("data write outside phase four");
  AST_ADDR_HOLD: assert property (!PHASE[0] |=> $stable(DATA_ADDR))
    else $error("data address moved mid cycle");
  AST_WREG_SLOT: assert property (!PHASE[3] |=> $stable(WORK_REG))
    else $error("working register changed outside phase four");
  AST_FLAGS_SLOT: assert property (!PHASE[0] |=> $stable(STATUS_FLAGS))
    else $error("flags changed at wrong time");
  AST_ONE_READ: assert property (DATA_RD_EN && CE |=> !DATA_RD_EN [*3])
    else $error("more than one read in a cycle");
  AST_FIRST_FETCH: assert property ($fell(RST) |-> fetch_only_s)
    else $error("data access in first cycle after reset");
  AST_RESET_STATE: assert property (disable iff (1'b0) RST && CE |=>
    PHASE == 4'h1 && PROG_ADDR == 12'h000 && WORK_REG == 8'h00)
    else $error("reset state wrong");
endmodule

bind quad_phase_fetch_execute_core core_props chk (.CORE_CLK, .RST, .CE, .MASTER_CLEAR_PIN_N,
  .PHASE, .PROG_ADDR, .DATA_ADDR, .DATA_RD_EN, .DATA_WR_EN, .WORK_REG, .STATUS_FLAGS);

`default_nettype wire

// >>> bench/test_quad_phase_fetch_execute_core.sv
`default_nettype none

module test_quad_phase_fetch_execute_core
  import core_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic clear_n = 1'b1;
  logic int_req = 1'b0;
  logic [INSTR_W-1:0] prog_data;
  logic [DATA_W-1:0] rdata;
  logic [PHASES-1:0] phase;
  logic [PC_W-1:0] paddr;
  logic [7:0] daddr;
  logic rd_en;
  logic wr_en;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] wreg;
  logic [2:0] flags;
  logic [INSTR_W-1:0] pq[$];
  logic [10:0] eq[$];
  int num_errors = 0;
  int n_tests = 0;

  always #20 clk = ~clk;

  quad_phase_fetch_execute_core dut (.CORE_CLK(clk), .RST(rst), .CE(ce),
    .MASTER_CLEAR_PIN_N(clear_n), .INT_REQ(int_req), .PROG_DATA(prog_data),
    .DATA_RDATA(rdata), .PHASE(phase), .PROG_ADDR(paddr), .DATA_ADDR(daddr),
    .DATA_RD_EN(rd_en), .DATA_WR_EN(wr_en), .DATA_WDATA(wdata), .WORK_REG(wreg),
    .STATUS_FLAGS(flags));

  mem_model mem (.clk, .prog_addr(paddr), .prog_data, .data_addr(daddr), .rd_en, .wr_en,
    .wdata, .rdata);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic next_ph(input int k);
    int i;
    @(negedge clk);
    for (i = 0; i < 20 && phase[k] !== 1'b1; i++)
      @(negedge clk);
    if (phase[k] !== 1'b1)
      chk(16'(phase), 16'hffff);
  endtask

  // Loads the program, pads with no-ops and restarts the core
  task automatic boot(input logic [INSTR_W-1:0] p[$]);
    rst = 1'b1;
    foreach (mem.rom[i])
      mem.rom[i] = (i < p.size()) ? p[i] : 14'h1000;
    repeat (10) @(negedge clk);
    rst = 1'b0;
  endtask

  task automatic op(input logic [INSTR_W-1:0] ins, input logic [7:0] w, input logic [2:0] f);
    pq.push_back(ins);
    eq.push_back({w, f});
  endtask

  // Literal op is 3,op,kk; file op is 0,op,dest:addr; expected is {w, z, dc, c}
  task automatic t_alu();
    pq = {};
    eq = {};
    op(14'h3d00, 8'h00, 3'h4);
    op(14'h33ff, 8'hff, 3'h0);
    op(14'h3301, 8'h00, 3'h7);
    op(14'h330f, 8'h0f, 3'h0);
    op(14'h3410, 8'h01, 3'h1);
    op(14'h3401, 8'h00, 3'h7);
    op(14'h333c, 8'h3c, 3'h0);
    op(14'h342c, 8'hf0, 3'h2);
    op(14'h350f, 8'h00, 3'h6);
    op(14'h36a5, 8'ha5, 3'h2);
    op(14'h37ff, 8'h5a, 3'h2);
    op(14'h3800, 8'hb4, 3'h2);
    op(14'h3b00, 8'hb5, 3'h2);
    op(14'h3900, 8'h5a, 3'h3);
    op(14'h3800, 8'hb5, 3'h2);
    op(14'h3a00, 8'h4a, 3'h2);
    op(14'h3c00, 8'h49, 3'h2);
    op(14'h3e00, 8'h94, 3'h2);
    op(14'h01a0, 8'h94, 3'h2);
    op(14'h0320, 8'h28, 3'h1);
    op(14'h0ba0, 8'h28, 3'h1);
    boot(pq);
    next_ph(1);
    next_ph(1);
    foreach (eq[i])
    begin
      next_ph(1);
      chk(16'({wreg, flags}), 16'(eq[i]));
      chk(16'(paddr), 16'(i + 2));
    end
    chk(16'(mem.ram[8'h20]), 16'h0095);
    $display("alu test done");
  endtask

  task automatic flow(input logic [INSTR_W-1:0] p[$], input logic [PC_W-1:0] a[$],
    input logic [7:0] w[$]);
    boot(p);
    foreach (a[i])
    begin
      next_ph(1);
      chk(16'(paddr), 16'(a[i]));
      chk(16'(wreg), 16'(w[i]));
    end
  endtask

  task automatic t_branch();
    flow('{14'h3d00, 14'h3307, 14'h2005, 14'h3d00, 14'h3d00, 14'h3301},
      '{12'h000, 12'h001, 12'h002, 12'h003, 12'h005, 12'h006, 12'h007},
      '{8'h00, 8'h00, 8'h00, 8'h07, 8'h07, 8'h07, 8'h08});
    $display("branch test done");
  endtask

  task automatic t_wrap();
    flow('{14'h2ffe}, '{12'h000, 12'h001, 12'hffe, 12'hfff, 12'h000},
      '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    $display("wrap test done");
  endtask

  // Pointer, counter low byte and status reached as data locations
  task automatic t_sfr();
    flow('{14'h3277, 14'h01a1, 14'h3221, 14'h0184, 14'h3d00, 14'h0300, 14'h320a, 14'h0182,
      14'h3d00, 14'h3d00, 14'h3206, 14'h0183},
      '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h007, 12'h008,
      12'h00a, 12'h00b, 12'h00c, 12'h00d},
      '{8'h00, 8'h00, 8'h77, 8'h77, 8'h21, 8'h21, 8'h00, 8'h77, 8'h0a, 8'h0a, 8'h0a, 8'h06,
      8'h06});
    chk(16'(flags), 16'h0006);
    chk(16'(mem.ram[8'h21]), 16'h0077);
    $display("special register test done");
  endtask

  task automatic t_irq();
    boot('{14'h1000});
    repeat (3) next_ph(1);
    next_ph(3);
    int_req = 1'b1;
    next_ph(0);
    int_req = 1'b0;
    next_ph(1);
    chk(16'(paddr), 16'h0004);
    next_ph(1);
    chk(16'(paddr), 16'h0005);
    $display("interrupt test done");
  endtask

  task automatic t_clear();
    boot('{14'h3355});
    repeat (4) next_ph(1);
    chk(16'(wreg), 16'h0055);
    clear_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(16'(phase), 16'h0001);
    chk(16'(paddr), 16'h0000);
    chk(16'(wreg), 16'h0000);
    clear_n = 1'b1;
    next_ph(1);
    chk(16'(paddr), 16'h0000);
    next_ph(1);
    chk(16'(paddr), 16'h0001);
    $display("master clear test done");
  endtask

  task automatic t_freeze();
    boot('{14'h1000});
    next_ph(1);
    ce = 1'b0;
    repeat (5) @(negedge clk);
    chk(16'(phase), 16'h0002);
    ce = 1'b1;
    @(negedge clk);
    chk(16'(phase), 16'h0004);
    $display("freeze test done");
  endtask

  initial
  begin
    t_alu();
    t_branch();
    t_wrap();
    t_sfr();
    t_irq();
    t_clear();
    t_freeze();
    summarize();
  end

  // All tests need well under 1000 clocks
  initial
  begin
    #100000;
    num_errors++;
    summarize();
  end
endmodule

`default_nettype wire
